// ### rtl/asr_pkg.sv
// Constants, types and timing counts for the asynchronous SRAM host controller
package asr_pkg;
    localparam int          ASR_ADDR_W     = 18;
    localparam int          ASR_DATA_W     = 16;
    localparam int          ASR_CLK_PS     = 40000;
    localparam int          ASR_ACCESS_PS  = 15000;
    localparam int          ASR_WRITE_PS   = 10000;
    localparam int          ASR_DSETUP_PS  = 7000;
    localparam int          ASR_FLOAT_PS   = 7000;
    localparam int          ASR_REDRIVE_PS = 3000;
    localparam int          ASR_READ_CYC   = (ASR_ACCESS_PS + ASR_CLK_PS - 1) / ASR_CLK_PS + 2;
    localparam int          ASR_WRITE_CYC  = (ASR_WRITE_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam int          ASR_FLOAT_CYC  = (ASR_FLOAT_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam int          ASR_CNT_W      = 4;
    localparam logic [3:0]  ASR_CNT_ONE    = 4'h1;
    localparam logic [3:0]  ASR_CNT_ZERO   = 4'h0;
    localparam logic [3:0]  ASR_RD_CNT     = 4'(ASR_READ_CYC);
    localparam logic [3:0]  ASR_WR_CNT     = 4'(ASR_WRITE_CYC);
    localparam logic [3:0]  ASR_FL_CNT     = 4'(ASR_FLOAT_CYC);

    typedef enum logic [2:0]
    {
        ASR_IDLE  = 3'h0,
        ASR_SETUP = 3'h1,
        ASR_WSTRB = 3'h3,
        ASR_WRCV  = 3'h2,
        ASR_RSTRB = 3'h6,
        ASR_RFLT  = 3'h7
    } asr_state_e;

    typedef struct packed
    {
        logic                  write;
        logic [1:0]            lane_n;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_s;

    typedef struct packed
    {
        logic                  chip_select_n;
        logic                  output_enable_n;
        logic                  write_enable_n;
        logic                  low_lane_select_n;
        logic                  high_lane_select_n;
        logic [ASR_ADDR_W-1:0] word_address;
    } asr_pins_s;
endpackage

// ### rtl/asr_ctrl.sv
// Host-side controller driving an asynchronous 16-bit static memory
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
    import asr_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic                  req_valid,
    input  wire asr_req_s              req,
    output var  logic                  req_ready,
    output var  logic                  rsp_valid,
    output var  logic [ASR_DATA_W-1:0] rsp_rdata,
    output var  asr_pins_s             pins,
    output var  logic [ASR_DATA_W-1:0] data_pins_out,
    output var  logic                  data_pins_oe_n,
    input  wire logic [ASR_DATA_W-1:0] data_pins_in
);
    asr_state_e            state;
    asr_state_e            next_state;
    logic [ASR_CNT_W-1:0]  cnt;
    logic [ASR_CNT_W-1:0]  next_cnt;
    asr_req_s              cur;
    asr_req_s              next_cur;
    asr_pins_s             next_pins;
    logic [ASR_DATA_W-1:0] next_dout;
    logic                  next_oe_n;
    logic                  next_ready;
    logic                  next_rsp_valid;
    logic [ASR_DATA_W-1:0] next_rdata;
    logic [ASR_DATA_W-1:0] din_meta;
    logic [ASR_DATA_W-1:0] din_sync;

    function automatic asr_pins_s idle_pins(input logic [ASR_ADDR_W-1:0] a);
        asr_pins_s p;
        p.chip_select_n      = 1'b1;
        p.output_enable_n    = 1'b1;
        p.write_enable_n     = 1'b1;
        p.low_lane_select_n  = 1'b1;
        p.high_lane_select_n = 1'b1;
        p.word_address       = a;
        return p;
    endfunction

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            din_meta <= '0;
            din_sync <= '0;
        end
        else
        begin
            din_meta <= data_pins_in;
            din_sync <= din_meta;
        end
    end

    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt;
        next_cur       = cur;
        next_pins      = pins;
        next_dout      = data_pins_out;
        next_oe_n      = data_pins_oe_n;
        next_ready     = 1'b0;
        next_rsp_valid = 1'b0;
        next_rdata     = rsp_rdata;
        case (state)
            ASR_IDLE:
            begin
                next_ready = 1'b1;
                if (req_valid && req_ready)
                begin
                    next_ready = 1'b0;
                    next_cur   = req;
                    // Address moves with all strobes high
                    next_pins  = idle_pins(req.addr);
                    next_state = ASR_SETUP;
                end
            end
            ASR_SETUP:
            begin
                next_pins.chip_select_n      = 1'b0;
                next_pins.low_lane_select_n  = cur.lane_n[0];
                next_pins.high_lane_select_n = cur.lane_n[1];
                if (cur.write)
                begin
                    // Host drives only with memory output disabled
                    next_pins.write_enable_n = 1'b0;
                    next_dout  = cur.wdata;
                    next_oe_n  = 1'b0;
                    next_cnt   = ASR_WR_CNT;
                    next_state = ASR_WSTRB;
                end
                else
                begin
                    next_pins.output_enable_n = 1'b0;
                    next_cnt   = ASR_RD_CNT;
                    next_state = ASR_RSTRB;
                end
            end
            ASR_WSTRB:
            begin
                // Strobes, address and data held over the pulse
                if (cnt <= ASR_CNT_ONE)
                begin
                    next_pins  = idle_pins(cur.addr);
                    next_state = ASR_WRCV;
                end
                else
                    next_cnt = cnt - ASR_CNT_ONE;
            end
            ASR_WRCV:
            begin
                // Data released one cycle after strobes rise
                next_oe_n  = 1'b1;
                next_ready = 1'b1;
                next_state = ASR_IDLE;
            end
            ASR_RSTRB:
            begin
                // Wait access plus synchroniser before sampling
                if (cnt <= ASR_CNT_ONE)
                begin
                    next_rdata     = din_sync;
                    next_rsp_valid = 1'b1;
                    next_pins      = idle_pins(cur.addr);
                    next_cnt       = ASR_FL_CNT;
                    next_state     = ASR_RFLT;
                end
                else
                    next_cnt = cnt - ASR_CNT_ONE;
            end
            ASR_RFLT:
            begin
                // Allow memory outputs to float before next drive
                if (cnt <= ASR_CNT_ONE)
                begin
                    next_cnt   = ASR_CNT_ZERO;
                    next_ready = 1'b1;
                    next_state = ASR_IDLE;
                end
                else
                    next_cnt = cnt - ASR_CNT_ONE;
            end
            default:
            begin
                next_state = ASR_IDLE;
                next_pins  = idle_pins('0);
                next_oe_n  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state          <= ASR_IDLE;
            cnt            <= ASR_CNT_ZERO;
            cur            <= '0;
            pins           <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
            data_pins_out  <= '0;
            data_pins_oe_n <= 1'b1;
            req_ready      <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_rdata      <= '0;
        end
        else
        begin
            state          <= next_state;
            cnt            <= next_cnt;
            cur            <= next_cur;
            pins           <= next_pins;
            data_pins_out  <= next_dout;
            data_pins_oe_n <= next_oe_n;
            req_ready      <= next_ready;
            rsp_valid      <= next_rsp_valid;
            rsp_rdata      <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ### testbench/asr_ctrl_monitor.sv
// Port checker for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_monitor
    import asr_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  nrst,
    input wire logic                  req_valid,
    input wire asr_req_s              req,
    input wire logic                  req_ready,
    input wire logic                  rsp_valid,
    input wire asr_pins_s             pins,
    input wire logic [ASR_DATA_W-1:0] data_pins_out,
    input wire logic                  data_pins_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic cs = !pins.chip_select_n;
    wire logic we = !pins.write_enable_n;
    wire logic oe = !pins.output_enable_n;
    wire logic [1:0] ln = {pins.high_lane_select_n, pins.low_lane_select_n};
    sequence s_wr; req_valid && req_ready && req.write; endsequence
    sequence s_rd; req_valid && req_ready && !req.write; endsequence
    sequence s_rd_on; (cs && oe && !we && data_pins_oe_n)[*2]; endsequence
    property p_clash; oe |-> data_pins_oe_n; endproperty
    a_clash: assert property (p_clash) else $error("host drives during read");
    property p_amove; $changed(pins.word_address) |-> !(we && cs) && !($past(we) && $past(cs)); endproperty
    a_amove: assert property (p_amove) else $error("address moved in write");
    property p_write;
        s_wr |-> ##1 !req_ready ##1 (we && cs && ln == $past(req.lane_n, 2) && !data_pins_oe_n
            && pins.word_address == $past(req.addr, 2) && data_pins_out == $past(req.wdata, 2))
            ##1 (!we && !data_pins_oe_n && $stable(data_pins_out)) ##1 req_ready;
    endproperty
    a_write: assert property (p_write) else $error("write cycle wrong");
    property p_wroe; we || $fell(we) |-> !oe; endproperty
    a_wroe: assert property (p_wroe) else $error("output enable in write");
    property p_read;
        s_rd |-> ##2 (pins.word_address == $past(req.addr, 2) && ln == $past(req.lane_n, 2))
            ##0 s_rd_on ##2 rsp_valid ##[0:1] req_ready;
    endproperty
    a_read: assert property (p_read) else $error("read cycle wrong");
    property p_pulse; rsp_valid |=> !rsp_valid && !oe; endproperty
    a_pulse: assert property (p_pulse) else $error("response too long");
    property p_idle; req_ready |-> !cs && !we && !oe && data_pins_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("strobes low when idle");
    property p_hold; oe && $past(oe) |-> $stable({ln, pins.word_address}); endproperty
    a_hold: assert property (p_hold) else $error("read inputs moved");
endmodule
bind asr_ctrl asr_ctrl_monitor u_asr_ctrl_monitor (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n));
`default_nettype wire

// ### testbench/asr_sram_model.sv
// Behavioural model of the asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int DLY_NS = 15
)
(
    input  wire asr_pins_s             pins,
    input  wire logic [ASR_DATA_W-1:0] data_pins_out,
    input  wire logic                  data_pins_oe_n,
    output wire logic [ASR_DATA_W-1:0] data_pins_in
);
    logic [ASR_DATA_W-1:0] mem [0:(1<<ASR_ADDR_W)-1];
    logic [ASR_DATA_W-1:0] word;
    wire logic wr = !pins.chip_select_n && !pins.write_enable_n;
    wire logic rd = !pins.chip_select_n && !pins.output_enable_n && pins.write_enable_n;
    always @(wr or pins or data_pins_out)
    begin
        if (wr && !pins.low_lane_select_n)
            mem[pins.word_address][7:0] = data_pins_out[7:0];
        if (wr && !pins.high_lane_select_n)
            mem[pins.word_address][15:8] = data_pins_out[15:8];
    end
    assign #(DLY_NS) word = mem[pins.word_address];
    // Undriven lanes show the inverse of the stored byte
    assign data_pins_in[7:0] = !data_pins_oe_n ? data_pins_out[7:0]
        : (rd && !pins.low_lane_select_n) ? word[7:0] : ~word[7:0];
    assign data_pins_in[15:8] = !data_pins_oe_n ? data_pins_out[15:8]
        : (rd && !pins.high_lane_select_n) ? word[15:8] : ~word[15:8];
endmodule
`default_nettype wire

// ### testbench/async_sram_byte_lane_timing_test.sv
// Testbench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_timing_test;
    import asr_pkg::*;
    typedef struct packed {logic w; logic [1:0] ln; logic [17:0] a; logic [15:0] d;} asr_row_s;
    logic                  mclk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  req_valid = 1'b0;
    asr_req_s              req = '0;
    logic                  req_ready, rsp_valid, data_pins_oe_n;
    logic [ASR_DATA_W-1:0] rsp_rdata, data_pins_out, data_pins_in, q;
    asr_pins_s             pins;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    asr_row_s rows [9] = '{'{1'h1, 2'h0, 18'h3FFFF, 16'hA55A}, '{1'h1, 2'h2, 18'h3FFFF, 16'h00C3},
        '{1'h0, 2'h0, 18'h3FFFF, 16'hA5C3}, '{1'h1, 2'h0, 18'h00000, 16'hFFFF},
        '{1'h1, 2'h1, 18'h00000, 16'h7E00}, '{1'h1, 2'h2, 18'h00000, 16'h0011},
        '{1'h0, 2'h2, 18'h00000, 16'h0011}, '{1'h0, 2'h1, 18'h00000, 16'h7E00},
        '{1'h0, 2'h0, 18'h00000, 16'h7E11}};
    asr_ctrl u_asr_ctrl (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_pins_out(data_pins_out),
        .data_pins_oe_n(data_pins_oe_n), .data_pins_in(data_pins_in));
    asr_sram_model u_asr_sram_model (.pins(pins), .data_pins_out(data_pins_out),
        .data_pins_oe_n(data_pins_oe_n), .data_pins_in(data_pins_in));
    always #20 mclk = ~mclk;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_op(input asr_row_s r);
        int i;
        @(posedge mclk);
        #1 req = '{r.w, r.ln, r.a, r.d};
        req_valid = 1'b1;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end while (req_ready !== 1'b1 && i < 40);
        #1 req_valid = 1'b0;
        while (!r.w && rsp_valid !== 1'b1 && i < 40)
        begin
            @(posedge mclk);
            #1 i++;
        end
        q = rsp_rdata & {{8{~r.ln[1]}}, {8{~r.ln[0]}}};
        if (i >= 40)
            n_fail++;
        if (!r.w)
            check("read data", q, r.d);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        check("strobes in reset", 16'({pins[22:18], data_pins_oe_n, req_ready}), 16'h007E);
        #1 nrst = 1'b1;
        foreach (rows[i])
            do_op(rows[i]);
        @(posedge mclk);
        #1 req = '{1'b0, 2'h0, 18'h3FFFF, 16'h0000};
        req_valid = 1'b1;
        repeat (3) @(posedge mclk);
        #1 nrst = 1'b0;
        req_valid = 1'b0;
        #1 check("strobes mid reset", 16'({pins[22:18], data_pins_oe_n}), 16'h003F);
        @(posedge mclk);
        #1 nrst = 1'b1;
        do_op(rows[2]);
        final_report();
    end
    initial
    begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
